/* File: hdl/mad_pkg.sv */
// Purpose: shared constants, modes and carriers of the multiply-add half slice
// Assumes: one half slice per instance, APB register access
// Notes: register layouts follow the field order of the packed structs below
package mad_pkg;
  // ==========================================================
  // widths and counts
  localparam int OP_W = 18;
  localparam int PROD_W = 38;
  localparam int SUM1_W = 39;
  localparam int ACC_W = 44;
  localparam int BANK_W = 72;
  localparam int HIGH_W = BANK_W - ACC_W;
  localparam int LANES = 4;
  localparam int BANKS = 4;
  localparam int RS_ROUND_POS = 18;
  localparam int RS_SAT_WIDTH = 36;
  localparam int MID_SHIFT = 18;
  localparam int HIGH_SHIFT = 36;
  localparam int HALF_OUT_W = 36;

  // ==========================================================
  // register map
  localparam logic [11:0] CFG_OFFSET = 12'h000;
  localparam logic [11:0] BANKMAP_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  // ==========================================================
  // modes
  typedef enum logic [1:0] {SIZE18, SIZE12, SIZE9} mad_size_e;
  typedef enum logic [1:0] {SEC_SUM4, SEC_ACCUM, SEC_CHAIN, SEC_FINAL36} mad_second_e;
  typedef enum logic [2:0] {
    OUT_SECOND, OUT_MULT, OUT_STAGE1, OUT_PIPE, OUT_ROUNDSAT
  } mad_outsel_e;
  typedef enum logic [1:0] {RND_SECOND, RND_MULT, RND_STAGE1, RND_PIPE} mad_rndsrc_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic shiftMode;
    logic signUse;
    mad_rndsrc_e roundSrc;
    mad_outsel_e outSel;
    logic outRegEn;
    logic signRegEn;
    logic multRegEn;
    logic inRegEn;
    logic pipeEn;
    logic accSub;
    logic sub1;
    logic sub0;
    mad_second_e second;
    mad_size_e size;
  } mad_cfg_s;

  typedef struct packed {
    logic [1:0] inBank;
    logic [1:0] multBank;
    logic [1:0] pipeBank;
    logic [1:0] secondBank;
    logic [1:0] outBank;
  } mad_bankmap_s;

  localparam mad_cfg_s CFG_RESET = '0;
  localparam mad_bankmap_s BANKMAP_RESET = '0;

  typedef struct packed {
    logic [LANES-1:0][OP_W-1:0] a;
    logic [LANES-1:0][OP_W-1:0] b;
  } mad_ops_s;

  typedef struct packed {
    logic aSigned;
    logic bSigned;
    logic roundEn;
    logic satEn;
    logic accumLoad;
    mad_outsel_e outSelDyn;
  } mad_dyn_s;

  typedef struct packed {
    logic [SUM1_W-1:0] s0;
    logic [SUM1_W-1:0] s1;
    logic [PROD_W-1:0] pLow;
    logic [PROD_W-1:0] pHigh;
  } mad_stage1_s;
endpackage

/* File: hdl/mad_reg_stage.sv */
// Purpose: one bank-controlled register stage of the half slice
// Assumes: clearN already combines system reset and the bank clear
// Notes: clears without waiting for an edge and holds cleared while low
`timescale 1ns/1ns
`default_nettype none
module mad_reg_stage #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic clearN,
  input wire logic enable,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // ==========================================================
  // storage
  always_ff @(posedge clock or negedge clearN) begin
    if (!clearN) begin
      q <= '0;
    end else if (enable) begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/mad_round_sat.sv */
// Purpose: round then saturate one signed lane
// Assumes: dataIn is two's complement
// Notes: rounding is half-up at ROUND_POS, saturation clamps to SAT_WIDTH bits
`timescale 1ns/1ns
`default_nettype none
module mad_round_sat #(
  parameter int WIDTH = 44,
  parameter int ROUND_POS = 18,
  parameter int SAT_WIDTH = 36
) (
  input wire logic [WIDTH-1:0] dataIn,
  input wire logic roundEn,
  input wire logic satEn,
  output logic [WIDTH-1:0] dataOut,
  output logic overflow
);
  localparam logic signed [WIDTH:0] MAX_V =
    (WIDTH+1)'((64'(1) << (SAT_WIDTH - 1)) - 64'(1));
  localparam logic signed [WIDTH:0] MIN_V = -MAX_V - (WIDTH+1)'(1);
  localparam logic [WIDTH:0] HALF_V = (WIDTH+1)'(64'(1) << (ROUND_POS - 1));

  logic signed [WIDTH:0] rounded;

  // ==========================================================
  // round first, then saturate the rounded value
  always_comb begin
    // one spare bit so the rounding carry is seen by the clamp
    rounded = {dataIn[WIDTH-1], dataIn};
    if (roundEn) begin
      rounded = rounded + $signed(HALF_V);
      rounded[ROUND_POS-1:0] = '0;
    end
    overflow = 1'b0;
    dataOut = rounded[WIDTH-1:0];
    if (satEn) begin
      if (rounded > MAX_V) begin
        dataOut = MAX_V[WIDTH-1:0];
        overflow = 1'b1;
      end else if (rounded < MIN_V) begin
        dataOut = MIN_V[WIDTH-1:0];
        overflow = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/mad_half_slice.sv */
// Purpose: multiply-add half slice: multipliers, two adder stages, round/saturate, outputs
// Assumes: operands arrive MSB-aligned in 18-bit lanes; APB access; single clock
// Notes: static modes live in APB registers, run-time controls are ports
//
// Operation
// - multipliers run at 9, 12 or 18 bits; four 18-bit ones build 36x36
// - a half gives four 9x9, three 12x12 or four 18x18 products
// - narrow operands sit in the lane MSBs with zeros below them
// - each operand is signed when its sign control is high, else unsigned
// - the product is signed when either operand is signed
// - one A sign and one B sign control serve the whole half
// - products keep full precision for every sign combination
// - first-stage adders take only products; add or subtract is static
// - first-stage sums feed pipeline, second stage, round unit or outputs
// - optional pipeline register adds one cycle, bypassed adds none
// - second stage: 36-bit final, four-sum, accumulator or chain summation
// - second-stage result goes to the round unit or the output register
// - two round-and-saturate units per half, rounding before saturation
// - round and saturate are enabled separately by high dynamic controls
// - round input: multiplier, first stage, pipeline or second stage
// - rounding and saturation only in 18-bit independent sizes
// - 44-bit second and output registers pair into a 72-bit bank
// - output selection is static except in shift mode, where a port drives it
// - chain mode registers the four-sum before the chain adder
// - stage registers pick one of four clock enables and clears
// - sign controls, inputs and products each have an optional register
// - halves share only the four enables and four clears
// - accumulate: load high loads the sum, low adds or subtracts it
`timescale 1ns/1ns
`default_nettype none
module mad_half_slice (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [mad_pkg::BANKS-1:0] bankEnable,
  input wire logic [mad_pkg::BANKS-1:0] asyncClearBank,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mad_pkg::mad_ops_s operands,
  input wire mad_pkg::mad_dyn_s dynCtrl,
  input wire logic [mad_pkg::ACC_W-1:0] cascadeSumIn,
  output logic [mad_pkg::BANK_W-1:0] resultOut,
  output logic [mad_pkg::ACC_W-1:0] cascadeSumOut,
  output logic productSigned,
  output logic [1:0] overflowFlags
);
  localparam int OPS_W = $bits(mad_pkg::mad_ops_s);
  localparam int ST1_W = $bits(mad_pkg::mad_stage1_s);
  localparam int PRODS_W = mad_pkg::LANES * mad_pkg::PROD_W;

  // ==========================================================
  // helpers
  function automatic logic pickBank(input logic [mad_pkg::BANKS-1:0] v,
                                    input logic [1:0] sel);
    return v[sel];
  endfunction

  function automatic logic signed [mad_pkg::PROD_W-1:0] mulLane(
      input logic [mad_pkg::OP_W-1:0] a, input logic [mad_pkg::OP_W-1:0] b,
      input logic sa, input logic sb, input mad_pkg::mad_size_e size);
    logic signed [mad_pkg::OP_W:0] ea;
    logic signed [mad_pkg::OP_W:0] eb;
    // narrow operands are MSB-aligned, so the lane top bits hold them
    case (size)
      mad_pkg::SIZE9: begin
        ea = {{10{sa & a[17]}}, a[17:9]};
        eb = {{10{sb & b[17]}}, b[17:9]};
      end
      mad_pkg::SIZE12: begin
        ea = {{7{sa & a[17]}}, a[17:6]};
        eb = {{7{sb & b[17]}}, b[17:6]};
      end
      default: begin
        ea = {sa & a[17], a};
        eb = {sb & b[17], b};
      end
    endcase
    // 19x19 signed gives the exact 38-bit result for any sign mix
    return ea * eb;
  endfunction

  function automatic logic signed [mad_pkg::SUM1_W-1:0] addSub(
      input logic [mad_pkg::PROD_W-1:0] x, input logic [mad_pkg::PROD_W-1:0] y,
      input logic sub);
    logic signed [mad_pkg::SUM1_W-1:0] ex;
    logic signed [mad_pkg::SUM1_W-1:0] ey;
    ex = mad_pkg::SUM1_W'($signed(x));
    ey = mad_pkg::SUM1_W'($signed(y));
    return sub ? ex - ey : ex + ey;
  endfunction

  function automatic logic [mad_pkg::BANK_W-1:0] packProducts(
      input logic [mad_pkg::LANES-1:0][mad_pkg::PROD_W-1:0] p,
      input mad_pkg::mad_size_e size);
    case (size)
      mad_pkg::SIZE9: return {p[3][17:0], p[2][17:0], p[1][17:0], p[0][17:0]};
      mad_pkg::SIZE12: return {p[2][23:0], p[1][23:0], p[0][23:0]};
      default: return {p[1][35:0], p[0][35:0]};
    endcase
  endfunction

  // ==========================================================
  // register file
  mad_pkg::mad_cfg_s cfgQ;
  mad_pkg::mad_bankmap_s bankQ;
  logic [31:0] prdataQ;
  logic rdHit;
  logic [31:0] rdData;
  logic statusSel;
  logic accessPhase;

  assign accessPhase = psel & penable;
  assign statusSel = (paddr == mad_pkg::STATUS_OFFSET);
  assign pready = 1'b1;
  assign pslverr = accessPhase & (~rdHit | (pwrite & statusSel));
  assign prdata = prdataQ;

  always_comb begin
    rdHit = 1'b1;
    rdData = 32'h00000000;
    case (paddr)
      mad_pkg::CFG_OFFSET: rdData = 32'(cfgQ);
      mad_pkg::BANKMAP_OFFSET: rdData = 32'(bankQ);
      mad_pkg::STATUS_OFFSET: rdData = {28'h0000000, overflowFlags, productSigned, 1'b0};
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfgQ <= mad_pkg::CFG_RESET;
    end else if (accessPhase && pwrite && paddr == mad_pkg::CFG_OFFSET) begin
      cfgQ <= mad_pkg::mad_cfg_s'(pwdata[$bits(mad_pkg::mad_cfg_s)-1:0]);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bankQ <= mad_pkg::BANKMAP_RESET;
    end else if (accessPhase && pwrite && paddr == mad_pkg::BANKMAP_OFFSET) begin
      bankQ <= mad_pkg::mad_bankmap_s'(pwdata[$bits(mad_pkg::mad_bankmap_s)-1:0]);
    end
  end

  // read data is captured in the setup cycle so it stands through access
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdataQ <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdataQ <= rdData;
    end
  end

  // ==========================================================
  // bank-controlled register stages
  // gated clear is asynchronous; banks only share enables and clears
  logic inEn, multEn, pipeEn, secondEn, outEn;
  logic inClrN, multClrN, pipeClrN, secondClrN, outClrN;

  assign inEn = pickBank(bankEnable, bankQ.inBank);
  assign multEn = pickBank(bankEnable, bankQ.multBank);
  assign pipeEn = pickBank(bankEnable, bankQ.pipeBank);
  assign secondEn = pickBank(bankEnable, bankQ.secondBank);
  assign outEn = pickBank(bankEnable, bankQ.outBank);
  assign inClrN = reset_n & ~pickBank(asyncClearBank, bankQ.inBank);
  assign multClrN = reset_n & ~pickBank(asyncClearBank, bankQ.multBank);
  assign pipeClrN = reset_n & ~pickBank(asyncClearBank, bankQ.pipeBank);
  assign secondClrN = reset_n & ~pickBank(asyncClearBank, bankQ.secondBank);
  assign outClrN = reset_n & ~pickBank(asyncClearBank, bankQ.outBank);

  mad_pkg::mad_ops_s opsQ;
  mad_pkg::mad_ops_s opsV;
  logic [1:0] signQ;
  logic signA;
  logic signB;

  mad_reg_stage #(.WIDTH(OPS_W)) inStage (
    .clock(clock), .clearN(inClrN), .enable(inEn), .d(operands), .q(opsQ)
  );
  mad_reg_stage #(.WIDTH(2)) signStage (
    .clock(clock), .clearN(inClrN), .enable(inEn),
    .d({dynCtrl.aSigned, dynCtrl.bSigned}), .q(signQ)
  );

  assign opsV = cfgQ.inRegEn ? opsQ : operands;
  // unused sign controls leave multiplication unsigned
  assign signA = cfgQ.signUse & (cfgQ.signRegEn ? signQ[1] : dynCtrl.aSigned);
  assign signB = cfgQ.signUse & (cfgQ.signRegEn ? signQ[0] : dynCtrl.bSigned);
  assign productSigned = signA | signB;

  // ==========================================================
  // multipliers
  logic mode36;
  logic [mad_pkg::LANES-1:0][mad_pkg::PROD_W-1:0] prodD;
  logic [mad_pkg::LANES-1:0][mad_pkg::PROD_W-1:0] prodQ;
  logic [mad_pkg::LANES-1:0][mad_pkg::PROD_W-1:0] prodV;

  assign mode36 = (cfgQ.second == mad_pkg::SEC_FINAL36);

  always_comb begin
    for (int i = 0; i < mad_pkg::LANES; i++) begin
      if (mode36) begin
        // partials of {a1,a0} x {b1,b0}: low halves are unsigned
        prodD[i] = mulLane(opsV.a[i%2], opsV.b[i/2], signA & (i % 2 == 1),
                           signB & (i / 2 == 1), mad_pkg::SIZE18);
      end else if (cfgQ.size == mad_pkg::SIZE12 && i == 3) begin
        prodD[i] = '0;
      end else begin
        prodD[i] = mulLane(opsV.a[i], opsV.b[i], signA, signB, cfgQ.size);
      end
    end
  end

  mad_reg_stage #(.WIDTH(PRODS_W)) multStage (
    .clock(clock), .clearN(multClrN), .enable(multEn), .d(prodD), .q(prodQ)
  );
  assign prodV = cfgQ.multRegEn ? prodQ : prodD;

  // ==========================================================
  // first stage and pipeline
  mad_pkg::mad_stage1_s st1D;
  mad_pkg::mad_stage1_s pipeQ;
  mad_pkg::mad_stage1_s st2;

  always_comb begin
    // only products reach the first-stage adders
    if (mode36) begin
      st1D.s0 = addSub(prodV[1], prodV[2], 1'b0);
    end else begin
      st1D.s0 = addSub(prodV[0], prodV[1], cfgQ.sub0);
    end
    st1D.s1 = addSub(prodV[2], prodV[3], cfgQ.sub1);
    st1D.pLow = prodV[0];
    st1D.pHigh = prodV[3];
  end

  mad_reg_stage #(.WIDTH(ST1_W)) pipeStage (
    .clock(clock), .clearN(pipeClrN), .enable(pipeEn), .d(st1D), .q(pipeQ)
  );
  assign st2 = cfgQ.pipeEn ? pipeQ : st1D;

  // ==========================================================
  // second stage and chain adder
  logic [mad_pkg::ACC_W-1:0] secondQ;
  logic [mad_pkg::ACC_W-1:0] outQ;
  logic signed [mad_pkg::ACC_W-1:0] sum4;
  logic [mad_pkg::ACC_W-1:0] secondSum;
  logic [mad_pkg::ACC_W-1:0] chainSum;
  logic [mad_pkg::BANK_W-1:0] final72;
  logic chainMode;

  assign chainMode = (cfgQ.second == mad_pkg::SEC_CHAIN);
  assign sum4 = mad_pkg::ACC_W'($signed(st2.s0)) + mad_pkg::ACC_W'($signed(st2.s1));
  assign final72 = (mad_pkg::BANK_W'($signed(st2.pHigh)) <<< mad_pkg::HIGH_SHIFT)
                 + (mad_pkg::BANK_W'($signed(st2.s0)) <<< mad_pkg::MID_SHIFT)
                 + mad_pkg::BANK_W'($signed(st2.pLow));
  // chain input must come from the previous slice, never from routing
  assign chainSum = secondQ + cascadeSumIn;

  always_comb begin
    case (cfgQ.second)
      mad_pkg::SEC_SUM4: secondSum = sum4;
      mad_pkg::SEC_CHAIN: secondSum = sum4;
      mad_pkg::SEC_FINAL36: secondSum = final72[mad_pkg::ACC_W-1:0];
      mad_pkg::SEC_ACCUM: begin
        // feedback taken from the output register
        if (dynCtrl.accumLoad) begin
          secondSum = sum4;
        end else begin
          secondSum = cfgQ.accSub ? outQ - sum4 : outQ + sum4;
        end
      end
      default: secondSum = sum4;
    endcase
  end

  // ==========================================================
  // round and saturate
  logic rsAllow;
  logic [mad_pkg::ACC_W-1:0] rs0In, rs1In, rs0Out, rs1Out;

  assign rsAllow = (cfgQ.size == mad_pkg::SIZE18) && !mode36;

  always_comb begin
    case (cfgQ.roundSrc)
      mad_pkg::RND_MULT: begin
        rs0In = mad_pkg::ACC_W'($signed(prodV[0]));
        rs1In = mad_pkg::ACC_W'($signed(prodV[2]));
      end
      mad_pkg::RND_STAGE1: begin
        rs0In = mad_pkg::ACC_W'($signed(st1D.s0));
        rs1In = mad_pkg::ACC_W'($signed(st1D.s1));
      end
      mad_pkg::RND_PIPE: begin
        rs0In = mad_pkg::ACC_W'($signed(pipeQ.s0));
        rs1In = mad_pkg::ACC_W'($signed(pipeQ.s1));
      end
      default: begin
        rs0In = secondSum;
        rs1In = chainSum;
      end
    endcase
  end

  mad_round_sat #(
    .WIDTH(mad_pkg::ACC_W), .ROUND_POS(mad_pkg::RS_ROUND_POS),
    .SAT_WIDTH(mad_pkg::RS_SAT_WIDTH)
  ) roundSat0 (
    .dataIn(rs0In), .roundEn(dynCtrl.roundEn & rsAllow),
    .satEn(dynCtrl.satEn & rsAllow), .dataOut(rs0Out), .overflow(overflowFlags[0])
  );
  mad_round_sat #(
    .WIDTH(mad_pkg::ACC_W), .ROUND_POS(mad_pkg::RS_ROUND_POS),
    .SAT_WIDTH(mad_pkg::RS_SAT_WIDTH)
  ) roundSat1 (
    .dataIn(rs1In), .roundEn(dynCtrl.roundEn & rsAllow),
    .satEn(dynCtrl.satEn & rsAllow), .dataOut(rs1Out), .overflow(overflowFlags[1])
  );

  // ==========================================================
  // output selection and register bank
  mad_pkg::mad_outsel_e selSrc;
  logic [mad_pkg::BANK_W-1:0] selected;
  logic [mad_pkg::ACC_W-1:0] secondD;
  logic [mad_pkg::ACC_W-1:0] outD;

  assign selSrc = cfgQ.shiftMode ? dynCtrl.outSelDyn : cfgQ.outSel;

  always_comb begin
    // two-lane views keep the low 36 bits of each lane
    case (selSrc)
      mad_pkg::OUT_MULT: selected = packProducts(prodV, cfgQ.size);
      mad_pkg::OUT_STAGE1: selected = {st1D.s1[35:0], st1D.s0[35:0]};
      mad_pkg::OUT_PIPE: selected = {pipeQ.s1[35:0], pipeQ.s0[35:0]};
      mad_pkg::OUT_ROUNDSAT: selected = {rs1Out[35:0], rs0Out[35:0]};
      mad_pkg::OUT_SECOND: begin
        selected = mode36 ? final72 : mad_pkg::BANK_W'($signed(secondSum));
      end
      default: selected = mad_pkg::BANK_W'($signed(secondSum));
    endcase
  end

  // 72-bit bank: second register upper part above the output register
  assign secondD = chainMode ? secondSum
                 : {16'h0000, selected[mad_pkg::BANK_W-1:mad_pkg::ACC_W]};
  assign outD = chainMode ? chainSum : selected[mad_pkg::ACC_W-1:0];

  mad_reg_stage #(.WIDTH(mad_pkg::ACC_W)) secondStage (
    .clock(clock), .clearN(secondClrN), .enable(secondEn), .d(secondD), .q(secondQ)
  );
  mad_reg_stage #(.WIDTH(mad_pkg::ACC_W)) outStage (
    .clock(clock), .clearN(outClrN), .enable(outEn), .d(outD), .q(outQ)
  );

  // chain mode always passes through the second register before the chain adder
  assign resultOut = cfgQ.outRegEn ? {secondQ[mad_pkg::HIGH_W-1:0], outQ}
                   : (chainMode ? mad_pkg::BANK_W'($signed(chainSum)) : selected);
  assign cascadeSumOut = outQ;
endmodule
`default_nettype wire

/* File: tb/mad_half_slice_sva.sv */
// Purpose: port checker of the half slice
// Assumes: bound to mad_half_slice, one clock domain
// Notes: config is invisible here; checks hold in every mode except the sign checks when signRegEn is set and the input bank enable is low
`timescale 1ns/1ns
`default_nettype none
module mad_half_slice_sva (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [mad_pkg::BANKS-1:0] bankEnable,
  input wire logic [mad_pkg::BANKS-1:0] asyncClearBank,
  input wire mad_pkg::mad_dyn_s dynCtrl,
  input wire logic [mad_pkg::ACC_W-1:0] cascadeSumOut,
  input wire logic productSigned,
  input wire logic [1:0] overflowFlags
);
  // ==========================================================
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic anySign;
  assign anySign = dynCtrl.aSigned | dynCtrl.bSigned;
  a_clear_now: assert property (&asyncClearBank |-> cascadeSumOut == '0)
    else $error("output not cleared by bank clear");
  a_clear_holds: assert property ((&asyncClearBank)[*3] |-> cascadeSumOut == '0)
    else $error("output left clear while held");
  a_reset_zero: assert property ($rose(reset_n) |-> cascadeSumOut == '0)
    else $error("output not zero after reset");
  a_hold_disabled: assert property ((bankEnable == '0 && asyncClearBank == '0) ##1
    asyncClearBank == '0 |-> $stable(cascadeSumOut))
    else $error("output moved with banks disabled");
  a_change_cause: assert property ($changed(cascadeSumOut) |-> $past(bankEnable) != '0 ||
    $past(asyncClearBank) != '0 || asyncClearBank != '0)
    else $error("output changed with no cause");
  a_sign_signed: assert property (productSigned |-> anySign || $past(anySign))
    else $error("signed product without signed operand");
  a_sign_unsigned: assert property (!anySign && !$past(anySign) |-> !productSigned)
    else $error("unsigned operands gave signed product");
  a_sat_gate: assert property (!dynCtrl.satEn |-> overflowFlags == 2'b00)
    else $error("clamp flagged with saturation off");
  cover property (productSigned);
  cover property (overflowFlags[0]);
  cover property (&asyncClearBank);
endmodule
bind mad_half_slice mad_half_slice_sva mad_half_slice_sva_inst (.clock(clock),
  .reset_n(reset_n), .bankEnable(bankEnable), .asyncClearBank(asyncClearBank),
  .dynCtrl(dynCtrl), .cascadeSumOut(cascadeSumOut), .productSigned(productSigned),
  .overflowFlags(overflowFlags));
`default_nettype wire

/* File: tb/mad_prev_slice.sv */
// Purpose: previous slice feeding the cascade sum input
// Assumes: value is loaded by the bench
// Notes: registered, so it only moves on an edge like a real slice
`timescale 1ns/1ns
`default_nettype none
module mad_prev_slice (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [mad_pkg::ACC_W-1:0] value,
  output logic [mad_pkg::ACC_W-1:0] sumOut
);
  // ==========================================================
  // cascade register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sumOut <= '0;
    end else if (load) begin
      sumOut <= value;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_multiply_add_datapath_half_block.sv */
// Purpose: self-checking bench of the half slice
// Assumes: APB with zero wait states, 10 MHz clock
// Notes: 36x36 and shift modes are never configured, so nothing checks them
`timescale 1ns/1ns
`default_nettype none
module tb_multiply_add_datapath_half_block;
  // ==========================================================
  // signals
  logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [3:0] bankEnable = 4'hF, asyncClearBank = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, productSigned, pLoad = 1'b0;
  mad_pkg::mad_ops_s ops = '0;
  mad_pkg::mad_dyn_s dyn = '0;
  logic [43:0] cascadeSumIn, cascadeSumOut, pValue = 44'h0;
  logic [71:0] resultOut;
  logic [1:0] overflowFlags;
  int n_errors = 0, comparisons = 0, cycles = 0;
  mad_half_slice mad_half_slice_inst (.clock(clock), .reset_n(reset_n),
    .bankEnable(bankEnable), .asyncClearBank(asyncClearBank), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .operands(ops), .dynCtrl(dyn),
    .cascadeSumIn(cascadeSumIn), .resultOut(resultOut), .cascadeSumOut(cascadeSumOut),
    .productSigned(productSigned), .overflowFlags(overflowFlags));
  mad_prev_slice mad_prev_slice_inst (.clock(clock), .reset_n(reset_n), .load(pLoad),
    .value(pValue), .sumOut(cascadeSumIn));
  initial begin
    forever #50 clock = ~clock;
  end
  // ==========================================================
  // shared tasks
  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic cfg_set(input mad_pkg::mad_cfg_s c);
    apb(1'b1, mad_pkg::CFG_OFFSET, 32'(c));
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    apb(1'b0, mad_pkg::CFG_OFFSET, 32'h0);
    check("cfg reset", rd, 32'h0);
    apb(1'b1, mad_pkg::BANKMAP_OFFSET, 32'h3FF);
    apb(1'b0, mad_pkg::BANKMAP_OFFSET, 32'h0);
    check("bank map", rd, 32'h3FF);
    apb(1'b1, mad_pkg::BANKMAP_OFFSET, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped", {er, rd}, 33'h100000000);
  endtask
  task automatic t_signs();
    mad_pkg::mad_cfg_s c;
    logic sa, sb, su;
    logic [43:0] ea, eb, ep;
    c = mad_pkg::CFG_RESET;
    for (int i = 0; i < 5; i++) begin
      su = (i < 4);
      sa = i[1] | !su;
      sb = i[0] | !su;
      c.signUse = su;
      cfg_set(c);
      ops.a[0] <= 18'h3FFFD;
      ops.b[0] <= 18'h3FFFB;
      dyn <= {sa, sb, 6'h00};
      ea = (sa && su) ? 44'hFFF_FFFF_FFFD : 44'h000_0003_FFFD;
      eb = (sb && su) ? 44'hFFF_FFFF_FFFB : 44'h000_0003_FFFB;
      ep = ea * eb;
      @(negedge clock);
      check("product", resultOut[43:0], ep);
      check("signed", productSigned, su & (sa | sb));
      @(posedge clock);
    end
  endtask
  task automatic t_sub();
    mad_pkg::mad_cfg_s c;
    mad_pkg::mad_ops_s o;
    c = mad_pkg::CFG_RESET;
    o = '0;
    o.a = {18'h00001, 18'h00005, 18'h00002, 18'h00007};
    o.b = {18'h00001, 18'h00005, 18'h00004, 18'h00003};
    for (int k = 0; k < 2; k++) begin
      c.sub0 = k[0];
      c.sub1 = k[0];
      cfg_set(c);
      ops <= o;
      dyn <= '0;
      @(negedge clock);
      check("sum of four", resultOut[43:0], k ? 44'h25 : 44'h37);
      @(posedge clock);
    end
  endtask
  task automatic t_pipe();
    mad_pkg::mad_cfg_s c;
    mad_pkg::mad_ops_s o;
    c = mad_pkg::CFG_RESET;
    c.pipeEn = 1'b1;
    c.outRegEn = 1'b1;
    cfg_set(c);
    o = '0;
    o.a[0] = 18'h00007;
    o.b[0] = 18'h00003;
    ops <= o;
    asyncClearBank <= 4'hF;
    for (int k = 0; k < 4; k++) begin
      @(negedge clock);
      check("pipe latency", cascadeSumOut, (k == 3) ? 44'h15 : 44'h0);
      @(posedge clock);
      asyncClearBank <= 4'h0;
    end
    bankEnable <= 4'h0;
    o.a[0] = 18'h00001;
    ops <= o;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("held", cascadeSumOut, 44'h15);
    @(posedge clock);
    asyncClearBank <= 4'hF;
    for (int k = 0; k < 4; k++) begin
      @(negedge clock);
      check("cleared", cascadeSumOut, 44'h0);
      @(posedge clock);
    end
    asyncClearBank <= 4'h0;
    bankEnable <= 4'hF;
  endtask
  task automatic t_acc();
    mad_pkg::mad_cfg_s c;
    c = mad_pkg::CFG_RESET;
    c.second = mad_pkg::SEC_ACCUM;
    c.outRegEn = 1'b1;
    cfg_set(c);
    ops.a[0] <= 18'h00003;
    ops.b[0] <= 18'h00005;
    dyn <= 8'h08;
    for (int k = 1; k < 4; k++) begin
      @(posedge clock);
      dyn <= 8'h00;
      @(negedge clock);
      check("accumulate", cascadeSumOut, 44'(15 * k));
    end
    @(posedge clock);
    c.second = mad_pkg::SEC_CHAIN;
    cfg_set(c);
    pLoad <= 1'b1;
    pValue <= 44'h64;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("chain sum", cascadeSumOut, 44'h73);
  endtask
  task automatic t_sat();
    mad_pkg::mad_cfg_s c;
    logic [7:0] dv [4];
    dv = '{8'hD0, 8'hC0, 8'hE0, 8'hD0};
    c = mad_pkg::CFG_RESET;
    c.signUse = 1'b1;
    c.outSel = mad_pkg::OUT_ROUNDSAT;
    cfg_set(c);
    ops <= {8{18'h1FFFF}};
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        c.size = mad_pkg::SIZE12;
        cfg_set(c);
      end
      dyn <= dv[i];
      @(negedge clock);
      check("overflow", overflowFlags[0], i == 0);
      @(posedge clock);
    end
    apb(1'b0, mad_pkg::STATUS_OFFSET, 32'h0);
    check("status", rd, 32'h2);
  endtask
  // ==========================================================
  // sequence and timeout
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_signs();
    t_sub();
    t_pipe();
    @(posedge clock);
    t_acc();
    @(posedge clock);
    t_sat();
    wrap_up();
  end
endmodule
`default_nettype wire
